//--- rtl/cpu_clock_source_monitor.sv
// CPU clock source selection and oscillator failure monitor
`timescale 1ns/1ps
`default_nettype none

module cpu_clock_source_monitor (
	// Clock, reset, enable
	input  wire logic                               clk,
	input  wire logic                               arst_n,
	input  wire logic                               ce,
	// Pins from outside
	input  wire logic                               crystal_input_pin,
	input  wire logic                               pll_free_clk,
	input  wire logic [2:0]                         clock_select_pins,
	// System config write port
	input  wire logic                               system_config_wr,
	input  wire logic [clk_src_pkg::SYSCFG_W-1:0]   system_config_wdata,
	// Interrupt request handshake
	input  wire logic                               osc_irq_ack,
	output logic                                    osc_irq_req,
	// Clock control
	output logic [1:0]                              cpu_clk_src,
	output logic                                    pll_power_on,
	output logic                                    pll_free_run,
	output logic [2:0]                              pll_in_div,
	output logic [6:0]                              pll_mul,
	output logic [2:0]                              pll_div,
	output logic                                    out_halve,
	output logic [4:0]                              pll_factor,
	output logic                                    pll_resync,
	// Status
	output logic [2:0]                              clock_mode,
	output logic                                    monitor_active,
	output logic                                    osc_monitor_disable
);
	// Synchronisers
	logic [2:0] xtal_s_q;
	logic [2:0] pllc_s_q;
	logic [2:0] pins_s1_q;
	logic [2:0] pins_s2_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			xtal_s_q  <= '0;
			pllc_s_q  <= '0;
			pins_s1_q <= '0;
			pins_s2_q <= '0;
		end else if (ce) begin
			xtal_s_q  <= {xtal_s_q[1:0], crystal_input_pin};
			pllc_s_q  <= {pllc_s_q[1:0], pll_free_clk};
			pins_s1_q <= clock_select_pins;
			pins_s2_q <= pins_s1_q;
		end
	end
	wire xtal_edge = xtal_s_q[1] ^ xtal_s_q[2];
	wire pll_tick  = pllc_s_q[1] && !pllc_s_q[2];

	// Strap capture after release
	logic [1:0]               strap_cnt_q;
	logic [2:0]               code_q;
	clk_src_pkg::src_state_t  state_q;
	clk_src_pkg::src_state_t  state_d;
	wire strap_done = (strap_cnt_q == 2'(clk_src_pkg::STRAP_SETTLE));
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_cnt_q <= '0;
			code_q      <= clk_src_pkg::CODE_RESET;
		end else if (ce && !strap_done) begin
			strap_cnt_q <= strap_cnt_q + 2'd1;
			code_q      <= pins_s2_q;
		end
	end

	// Mode decode
	wire ext_mode = (code_q == clk_src_pkg::CODE_DIRECT) ||
		(code_q == clk_src_pkg::CODE_PRESCL);
	wire pres_mode = (code_q == clk_src_pkg::CODE_PRESCL);

	// Monitor disable bit, reset clear
	logic dis_q;
	wire  dis_wr = ce && strap_done && system_config_wr;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dis_q <= 1'b0;
		end else if (dis_wr) begin
			dis_q <= system_config_wdata[clk_src_pkg::MON_DIS_BIT];
		end
	end

	// Monitor counter
	wire mon_en = (state_q == clk_src_pkg::ST_EXT) && !dis_q;
	wire mon_ovf;
	osc_mon_counter #(
		.LIMIT (clk_src_pkg::MON_LIMIT),
		.W     (clk_src_pkg::MON_CNT_W)
	) u_mon (
		.clk      (clk),
		.arst_n   (arst_n),
		.ce       (ce),
		.enable   (mon_en),
		.tick     (pll_tick),
		.clear    (xtal_edge),
		.overflow (mon_ovf),
		.count    ()
	);

	// Source state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			clk_src_pkg::ST_STRAP: begin
				if (strap_done) begin
					state_d = ext_mode ? clk_src_pkg::ST_EXT :
						clk_src_pkg::ST_PLL;
				end
			end
			clk_src_pkg::ST_EXT: begin
				if (mon_ovf) begin
					state_d = clk_src_pkg::ST_BACKUP;
				end
			end
			clk_src_pkg::ST_BACKUP: begin
				state_d = clk_src_pkg::ST_BACKUP;
			end
			default: begin
				state_d = clk_src_pkg::ST_PLL;
			end
		endcase
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= clk_src_pkg::ST_STRAP;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// Interrupt request, set wins over ack
	logic irq_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= mon_ovf || (irq_q && !osc_irq_ack);
		end
	end

	// Divider table
	logic [2:0] in_div_d;
	logic [6:0] mul_d;
	logic [2:0] div_d;
	logic [4:0] fact_d;
	always_comb begin
		in_div_d = clk_src_pkg::IN_DIV_1;
		mul_d    = clk_src_pkg::MUL_NONE;
		div_d    = clk_src_pkg::DIV_NONE;
		fact_d   = clk_src_pkg::FACT_1;
		case (code_q)
			clk_src_pkg::CODE_X4: begin
				in_div_d = clk_src_pkg::IN_DIV_4;
				mul_d    = clk_src_pkg::MUL_64;
				div_d    = clk_src_pkg::DIV_4;
				fact_d   = clk_src_pkg::FACT_4;
			end
			clk_src_pkg::CODE_X3: begin
				in_div_d = clk_src_pkg::IN_DIV_4;
				mul_d    = clk_src_pkg::MUL_48;
				div_d    = clk_src_pkg::DIV_4;
				fact_d   = clk_src_pkg::FACT_3;
			end
			clk_src_pkg::CODE_X8: begin
				in_div_d = clk_src_pkg::IN_DIV_4;
				mul_d    = clk_src_pkg::MUL_64;
				div_d    = clk_src_pkg::DIV_2;
				fact_d   = clk_src_pkg::FACT_8;
			end
			clk_src_pkg::CODE_X5: begin
				in_div_d = clk_src_pkg::IN_DIV_4;
				mul_d    = clk_src_pkg::MUL_40;
				div_d    = clk_src_pkg::DIV_2;
				fact_d   = clk_src_pkg::FACT_5;
			end
			clk_src_pkg::CODE_X10: begin
				in_div_d = clk_src_pkg::IN_DIV_2;
				mul_d    = clk_src_pkg::MUL_40;
				div_d    = clk_src_pkg::DIV_2;
				fact_d   = clk_src_pkg::FACT_10;
			end
			clk_src_pkg::CODE_X16: begin
				in_div_d = clk_src_pkg::IN_DIV_2;
				mul_d    = clk_src_pkg::MUL_64;
				div_d    = clk_src_pkg::DIV_2;
				fact_d   = clk_src_pkg::FACT_16;
			end
			default: begin
				in_div_d = clk_src_pkg::IN_DIV_1;
			end
		endcase
	end

	// Resync on every F-th crystal transition
	logic [4:0] edge_cnt_q;
	wire        pll_run  = (state_q == clk_src_pkg::ST_PLL);
	wire        f_reach  = pll_run && xtal_edge &&
		(edge_cnt_q == fact_d - 5'd1);
	logic [4:0] edge_cnt_d;
	assign edge_cnt_d = !pll_run ? 5'd0 :
		(f_reach ? 5'd0 : (xtal_edge ? edge_cnt_q + 5'd1 : edge_cnt_q));
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			edge_cnt_q <= '0;
		end else if (ce) begin
			edge_cnt_q <= edge_cnt_d;
		end
	end

	// Source and power selection
	wire [1:0] src_d = (state_q == clk_src_pkg::ST_BACKUP) ?
		clk_src_pkg::SRC_PLL_FREE :
		(pll_run ? clk_src_pkg::SRC_PLL_LOCK :
		(pres_mode ? clk_src_pkg::SRC_XTAL_DIV : clk_src_pkg::SRC_XTAL));
	wire pwr_d  = pll_run || (state_q == clk_src_pkg::ST_BACKUP) ||
		((state_q == clk_src_pkg::ST_EXT) && !dis_q);
	wire free_d = !pll_run && pwr_d;

	// Registered outputs
	logic [1:0] src_q;
	logic       pwr_q;
	logic       free_q;
	logic [2:0] in_div_q;
	logic [6:0] mul_q;
	logic [2:0] div_q;
	logic       halve_q;
	logic [4:0] fact_q;
	logic       resync_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			src_q    <= clk_src_pkg::SRC_XTAL;
			pwr_q    <= 1'b0;
			free_q   <= 1'b0;
			in_div_q <= clk_src_pkg::IN_DIV_1;
			mul_q    <= clk_src_pkg::MUL_NONE;
			div_q    <= clk_src_pkg::DIV_NONE;
			halve_q  <= 1'b0;
			fact_q   <= clk_src_pkg::FACT_1;
			resync_q <= 1'b0;
		end else if (ce) begin
			src_q    <= src_d;
			pwr_q    <= pwr_d;
			free_q   <= free_d;
			in_div_q <= in_div_d;
			mul_q    <= mul_d;
			div_q    <= div_d;
			halve_q  <= pres_mode;
			fact_q   <= fact_d;
			resync_q <= f_reach;
		end
	end

	assign cpu_clk_src         = src_q;
	assign pll_power_on        = pwr_q;
	assign pll_free_run        = free_q;
	assign pll_in_div          = in_div_q;
	assign pll_mul             = mul_q;
	assign pll_div             = div_q;
	assign out_halve           = halve_q;
	assign pll_factor          = fact_q;
	assign pll_resync          = resync_q;
	assign osc_irq_req         = irq_q;
	assign clock_mode          = code_q;
	assign monitor_active      = mon_en;
	assign osc_monitor_disable = dis_q;

	mon_default_on_a: assert property (@(posedge clk) disable iff (!arst_n)
		!strap_done |-> !dis_q)
		else $error("monitor not enabled after reset");
	dis_write_a: assert property (@(posedge clk) disable iff (!arst_n)
		dis_wr && system_config_wdata[clk_src_pkg::MON_DIS_BIT] |=>
		!mon_en && dis_q)
		else $error("disable write did not stop the monitor");
	mon_mode_only_a: assert property (@(posedge clk) disable iff (!arst_n)
		mon_en |-> ext_mode)
		else $error("monitor running in pll mode");
	backup_switch_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && mon_ovf |=> state_q == clk_src_pkg::ST_BACKUP && irq_q
		##1 cpu_clk_src == clk_src_pkg::SRC_PLL_FREE)
		else $error("overflow did not switch to backup clock");
	backup_stays_a: assert property (@(posedge clk) disable iff (!arst_n)
		state_q == clk_src_pkg::ST_BACKUP |=>
		state_q == clk_src_pkg::ST_BACKUP)
		else $error("left backup clock without reset");
	dis_pll_off_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && dis_q && state_q == clk_src_pkg::ST_EXT |=>
		!pll_power_on && cpu_clk_src != clk_src_pkg::SRC_PLL_FREE)
		else $error("pll left on while monitor disabled");
	pll_select_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && state_q != clk_src_pkg::ST_STRAP && !ext_mode |=>
		cpu_clk_src == clk_src_pkg::SRC_PLL_LOCK && pll_power_on)
		else $error("pll code did not select pll clock");
	resync_pll_a: assert property (@(posedge clk) disable iff (!arst_n)
		pll_resync |-> $past(xtal_edge) && $past(pll_run))
		else $error("resync outside pll mode");
	code_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
		strap_done |=> $stable(code_q))
		else $error("clock code changed after capture");
endmodule

`default_nettype wire

//--- rtl/osc_mon_counter.sv
// Shared constants and the oscillator monitor counter
`timescale 1ns/1ps
`default_nettype none

package clk_src_pkg;
	localparam int          MON_LIMIT    = 16;
	localparam int          MON_CNT_W    = 5;
	localparam int          SYSCFG_W     = 16;
	localparam int          MON_DIS_BIT  = 4;
	localparam int          STRAP_SETTLE = 3;
	localparam logic [2:0]  CODE_X4      = 3'h7;
	localparam logic [2:0]  CODE_X3      = 3'h6;
	localparam logic [2:0]  CODE_X8      = 3'h5;
	localparam logic [2:0]  CODE_X5      = 3'h4;
	localparam logic [2:0]  CODE_DIRECT  = 3'h3;
	localparam logic [2:0]  CODE_X10     = 3'h2;
	localparam logic [2:0]  CODE_PRESCL  = 3'h1;
	localparam logic [2:0]  CODE_X16     = 3'h0;
	localparam logic [2:0]  CODE_RESET   = 3'h7;
	localparam logic [2:0]  IN_DIV_1     = 3'h1;
	localparam logic [2:0]  IN_DIV_2     = 3'h2;
	localparam logic [2:0]  IN_DIV_4     = 3'h4;
	localparam logic [6:0]  MUL_64       = 7'h40;
	localparam logic [6:0]  MUL_48       = 7'h30;
	localparam logic [6:0]  MUL_40       = 7'h28;
	localparam logic [6:0]  MUL_NONE     = 7'h00;
	localparam logic [2:0]  DIV_4        = 3'h4;
	localparam logic [2:0]  DIV_2        = 3'h2;
	localparam logic [2:0]  DIV_NONE     = 3'h0;
	localparam logic [4:0]  FACT_1       = 5'h01;
	localparam logic [4:0]  FACT_3       = 5'h03;
	localparam logic [4:0]  FACT_4       = 5'h04;
	localparam logic [4:0]  FACT_5       = 5'h05;
	localparam logic [4:0]  FACT_8       = 5'h08;
	localparam logic [4:0]  FACT_10      = 5'h0a;
	localparam logic [4:0]  FACT_16      = 5'h10;
	localparam logic [1:0]  SRC_XTAL     = 2'h0;
	localparam logic [1:0]  SRC_XTAL_DIV = 2'h1;
	localparam logic [1:0]  SRC_PLL_LOCK = 2'h2;
	localparam logic [1:0]  SRC_PLL_FREE = 2'h3;
	typedef enum logic [1:0] {
		ST_STRAP,
		ST_EXT,
		ST_BACKUP,
		ST_PLL
	} src_state_t;
endpackage

module osc_mon_counter #(
	parameter int LIMIT = clk_src_pkg::MON_LIMIT,
	parameter int W     = clk_src_pkg::MON_CNT_W
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         ce,
	// Counting events
	input  wire logic         enable,
	input  wire logic         tick,
	input  wire logic         clear,
	// Result
	output logic              overflow,
	output logic [W-1:0]      count
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	wire          at_top = (cnt_q == W'(LIMIT - 1));

	// Clear wins over a tick in the same cycle
	assign overflow = enable && tick && !clear && at_top;
	assign cnt_d    = (!enable || clear) ? '0 :
		(overflow ? '0 : (tick ? cnt_q + W'(1) : cnt_q));
	assign count    = cnt_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
		end else if (ce) begin
			cnt_q <= cnt_d;
		end
	end

	tick_count_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && enable && tick && !clear && !at_top |=> cnt_q == $past(cnt_q) + W'(1))
		else $error("monitor counter missed a pll cycle");
	edge_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && clear |=> cnt_q == '0)
		else $error("crystal transition did not clear counter");
	overflow_at_a: assert property (@(posedge clk) disable iff (!arst_n)
		overflow |-> cnt_q == W'(LIMIT - 1) && tick)
		else $error("overflow not at the sixteenth pll cycle");
endmodule

`default_nettype wire

//--- tb/xtal_pll_source_model.sv
// Crystal oscillator and free-running PLL clock source model
`timescale 1ns/1ps
`default_nettype none

module xtal_pll_source_model #(
	parameter int XTAL_HALF  = 50,
	parameter int XTAL_PHASE = 5,
	parameter int PLL_HALF  = 80
) (
	// Controls
	input  wire logic run,
	input  wire logic pll_on,
	// Clocks
	output logic      xtal,
	output logic      pll
);
	initial xtal = 1'b0;
	initial pll = 1'b0;

	// Stopped crystal holds its last level, edges kept off clk edges
	initial begin
		#(XTAL_PHASE);
		forever begin
			#(XTAL_HALF);
			if (run) xtal = ~xtal;
		end
	end

	// Free-running PLL clock only while powered
	always begin
		#(PLL_HALF);
		pll = pll_on ? ~pll : 1'b0;
	end
endmodule

`default_nettype wire

//--- tb/cpu_clock_source_monitor_test.sv
// Self-checking bench for the clock source monitor
`timescale 1ns/1ps
`default_nettype none

module cpu_clock_source_monitor_test;
	logic                               clk = 1'b0;
	logic                               arst_n = 1'b0;
	logic                               xt_run = 1'b1;
	logic                               xtal;
	logic                               pll;
	logic [2:0]                         pins = 3'h7;
	logic                               wr = 1'b0;
	logic [clk_src_pkg::SYSCFG_W-1:0]   wdata = '0;
	logic                               ack = 1'b0;
	logic                               irq;
	logic                               halve;
	logic                               pwr;
	logic                               free;
	logic                               resync;
	logic                               mon_act;
	logic                               mon_dis;
	logic [1:0]                         src;
	logic [2:0]                         in_div;
	logic [2:0]                         div;
	logic [2:0]                         mode;
	logic [6:0]                         mul;
	logic [4:0]                         fact;
	logic [22:0]                        ctrl;
	int                                 errors = 0;
	int                                 cmp_count = 0;
	int                                 seed = 14661;
	int                                 xt_n = 0;
	int                                 rs_n = 0;
	bit                                 cnt_en = 1'b0;

	assign ctrl = {src, pwr, free, in_div, mul, div, halve, fact};

	always #10 clk = ~clk;
	always @(xtal) if (cnt_en) xt_n++;
	always @(posedge clk) if (cnt_en && resync === 1'b1) rs_n++;

	cpu_clock_source_monitor i_cpu_clock_source_monitor (
		.clk                 (clk),
		.arst_n              (arst_n),
		.ce                  (1'b1),
		.crystal_input_pin   (xtal),
		.pll_free_clk        (pll),
		.clock_select_pins   (pins),
		.system_config_wr    (wr),
		.system_config_wdata (wdata),
		.osc_irq_ack         (ack),
		.osc_irq_req         (irq),
		.cpu_clk_src         (src),
		.pll_power_on        (pwr),
		.pll_free_run        (free),
		.pll_in_div          (in_div),
		.pll_mul             (mul),
		.pll_div             (div),
		.out_halve           (halve),
		.pll_factor          (fact),
		.pll_resync          (resync),
		.clock_mode          (mode),
		.monitor_active      (mon_act),
		.osc_monitor_disable (mon_dis)
	);

	xtal_pll_source_model i_xtal_pll_source_model (
		.run    (xt_run),
		.pll_on (pwr),
		.xtal   (xtal),
		.pll    (pll)
	);

	// Expected clock control word for a code and monitor enable
	function automatic logic [22:0] exp_ctrl(input logic [2:0] c,
		input logic mon);
		logic [17:0] t;
		logic        pl;
		logic [1:0]  s;
		pl = (c != 3'h3) && (c != 3'h1);
		s = (c == 3'h3) ? 2'h0 : ((c == 3'h1) ? 2'h1 : 2'h2);
		case (c)
		3'h7: t = {3'h4, 7'h40, 3'h4, 5'h04};
		3'h6: t = {3'h4, 7'h30, 3'h4, 5'h03};
		3'h5: t = {3'h4, 7'h40, 3'h2, 5'h08};
		3'h4: t = {3'h4, 7'h28, 3'h2, 5'h05};
		3'h2: t = {3'h2, 7'h28, 3'h2, 5'h0a};
		3'h0: t = {3'h2, 7'h40, 3'h2, 5'h10};
		default: t = {3'h1, 7'h00, 3'h0, 5'h01};
		endcase
		return {s, pl | mon, !pl & mon, t[17:5], c == 3'h1, t[4:0]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic do_reset(input logic [2:0] c);
		arst_n = 1'b0;
		pins = c;
		tick(5);
		arst_n = 1'b1;
		tick(3);
		pins = 3'($random(seed));
		tick(3);
	endtask

	task automatic cfg_wr(input logic dis);
		wdata = $random(seed);
		wdata[clk_src_pkg::MON_DIS_BIT] = dis;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		tick(2);
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		final_report;
	end

	initial begin
		tick(1);
		// Every strap code
		for (int c = 0; c < 8; c++) begin
			do_reset(c[2:0]);
			chk(ctrl, exp_ctrl(c[2:0], 1'b1), "ctrl");
			chk(mode, c[2:0], "mode");
			chk(mon_act, c == 3 || c == 1, "mon");
		end
		$display("test strap done");
		// Failure detection and switchover
		do_reset(3'h3);
		xt_run = 1'b0;
		tick(96);
		xt_run = 1'b1;
		tick(40);
		chk(irq, 1'b0, "short gap");
		xt_run = 1'b0;
		tick(112);
		chk(irq, 1'b0, "early irq");
		for (int i = 0; i < 60 && irq !== 1'b1; i++) tick(1);
		chk(irq, 1'b1, "irq");
		tick(2);
		chk(src, 2'h3, "backup");
		xt_run = 1'b1;
		tick(60);
		chk(src, 2'h3, "sticky");
		ack = 1'b1;
		tick(1);
		ack = 1'b0;
		tick(1);
		chk(irq, 1'b0, "ack");
		do_reset(3'h3);
		chk(src, 2'h0, "restore");
		$display("test failover done");
		// Monitor disable in prescaler mode
		do_reset(3'h1);
		cfg_wr(1'b1);
		chk(mon_dis, 1'b1, "disable");
		chk(ctrl, exp_ctrl(3'h1, 1'b0), "off ctrl");
		xt_run = 1'b0;
		tick(160);
		chk(irq, 1'b0, "off irq");
		xt_run = 1'b1;
		cfg_wr(1'b0);
		chk(mon_act, 1'b1, "reenable");
		$display("test disable done");
		// PLL mode resync and no monitoring
		xt_run = 1'b0;
		do_reset(3'h7);
		chk(mon_act, 1'b0, "pll mon");
		xt_n = 0;
		rs_n = 0;
		cnt_en = 1'b1;
		xt_run = 1'b1;
		tick(60 + ($unsigned($random(seed)) % 40));
		xt_run = 1'b0;
		tick(10);
		cnt_en = 1'b0;
		chk(rs_n, xt_n / 4, "resync");
		tick(160);
		chk(irq, 1'b0, "pll irq");
		chk(src, 2'h2, "pll src");
		$display("test pll done");
		final_report;
	end
endmodule

`default_nettype wire
